// [rtl/dsm_pkg.sv]
// drive state machine package: controlword layout, states, timing
// assumes a single 20 MHz drive clock on both ends
package dsm_pkg;

  // ----------------------------------------
  // controlword layout
  // ----------------------------------------
  localparam int CW_W        = 16;
  localparam int CW_SWITCH   = 0;
  localparam int CW_VOLTAGE  = 1;
  localparam int CW_QSTOP    = 2;
  localparam int CW_ENOP     = 3;
  localparam int CW_FRESET   = 7;

  localparam logic [CW_W-1:0] CW_NONE      = 16'h0000;
  localparam logic [CW_W-1:0] CW_SHUTDOWN  = 16'h0006;
  localparam logic [CW_W-1:0] CW_SWITCH_ON = 16'h0007;
  localparam logic [CW_W-1:0] CW_DIS_VOLT  = 16'h0000;
  localparam logic [CW_W-1:0] CW_QUICKSTOP = 16'h0002;
  localparam logic [CW_W-1:0] CW_DIS_OP    = 16'h0007;
  localparam logic [CW_W-1:0] CW_EN_OP     = 16'h000f;
  localparam logic [CW_W-1:0] CW_FAULT_RST = 16'h0080;

  // ----------------------------------------
  // states, reported as a 3-bit code
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_NOT_READY,
    ST_SW_ON_DIS,
    ST_READY,
    ST_SWITCHED_ON,
    ST_OP_ENABLED,
    ST_QSTOP_ACTIVE,
    ST_FAULT_REACT,
    ST_FAULT
  } dsm_state_t;

  // ----------------------------------------
  // quick-stop option codes, fault reset hold time
  // ----------------------------------------
  localparam logic [3:0] QS_OPT_AUTO_MIN = 4'h1;
  localparam logic [3:0] QS_OPT_AUTO_MAX = 4'h4;
  localparam int CLK_HZ         = 20_000_000;
  localparam int FR_HOLD_MS     = 10;
  localparam int FR_HOLD_CYCLES = FR_HOLD_MS * (CLK_HZ / 1000);

endpackage

// [rtl/dsm_link_if.sv]
// interface between the network master and the drive state machine
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface dsm_link_if import dsm_pkg::*; (
  input wire logic CLK
);
  logic             cyclic_up;   // cyclic i/o established
  logic [CW_W-1:0]  controlword; // master's controlword
  dsm_state_t       state;       // drive state back to master

  modport drive  (input cyclic_up, input controlword, output state);
  modport master (output cyclic_up, output controlword, input state);
endinterface

// [rtl/dsm_drive.sv]
// drive end: decodes the controlword and steps the power/operation states
// assumes controlword, cyclic_up come from same-clock logic; alarm and
// power/stop status pins are asynchronous and are synchronised here
//
// Contract
// - start in not ready after power-up
// - obey commands only once cyclic i/o up
// - leave initial state alone on control power
// - shutdown 0x110, switch on 0,0,1,1,1
// - disable voltage fr0 ev0; quick stop fr0 qs0 ev1
// - disable/enable operation decoded on bit 3
// - switch on closes relay, enters switched on
// - enable operation performs servo-on
// - disable operation performs servo-off
// - shutdown: transitions 2,6,8; 6 opens relay
// - disable voltage/quick stop: 7,10; voltage also 9
// - quick stop from enabled starts deceleration
// - quick stop exits on done or disable voltage
// - alarm enters fault reaction, then fault
// - fault reset rising edge clears alarms, exits fault
// - master holds fault reset for ten ms
// - no return from quick stop to enabled
// - shortcut switch on and enable operation accepted
`timescale 1ns/10ps
module dsm_drive import dsm_pkg::*; (
  input  wire logic CLK,                 // drive clock
  input  wire logic RSTN,                // async reset, active low
  dsm_link_if.drive LINK,                // master side
  input  wire logic CTRL_PWR_OK,         // control circuit power up
  input  wire logic MAIN_PWR_OK,         // main circuit power present
  input  wire logic ALARM,               // alarm raised
  input  wire logic ALARM_RESETTABLE,    // current alarm may be reset
  input  wire logic REACT_DONE,          // fault reaction finished
  input  wire logic QSTOP_DONE,          // quick-stop deceleration done
  input  wire logic [3:0] QS_OPTION,     // quick-stop option code (static)
  output logic      MAIN_CIRCUIT_RELAY,  // relay closed
  output logic      SERVO_ON,            // servo on
  output logic      QSTOP_DECEL,         // quick-stop deceleration running
  output logic      ALARM_CLEAR,         // one-cycle alarm clear pulse
  output logic      FAULT_ACTIVE         // in fault reaction or fault
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic       ctrl_ok;
  logic       main_ok;
  logic       alarm;
  logic       react_done;
  logic       qstop_done;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {CTRL_PWR_OK, MAIN_PWR_OK, ALARM, REACT_DONE, QSTOP_DONE};
      sync2_ff <= sync1_ff;
    end
  end
  assign {ctrl_ok, main_ok, alarm, react_done, qstop_done} = sync2_ff;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  logic [CW_W-1:0] cw;
  logic            fr_prev_ff;
  logic            cmd_shutdown;
  logic            cmd_switch_on;
  logic            cmd_dis_volt;
  logic            cmd_qstop;
  logic            cmd_en_op;
  logic            cmd_dis_op;
  logic            cmd_fault_rst;
  logic            qs_auto;

  // gated so a stale controlword before cyclic i/o does nothing
  assign cw = LINK.cyclic_up ? LINK.controlword : CW_NONE;

  assign cmd_shutdown  = !cw[CW_FRESET] && cw[CW_QSTOP] && cw[CW_VOLTAGE] && !cw[CW_SWITCH];
  assign cmd_switch_on = !cw[CW_FRESET] && !cw[CW_ENOP] && cw[CW_QSTOP] && cw[CW_VOLTAGE]
                         && cw[CW_SWITCH];
  assign cmd_dis_volt  = !cw[CW_FRESET] && !cw[CW_VOLTAGE];
  assign cmd_qstop     = !cw[CW_FRESET] && !cw[CW_QSTOP] && cw[CW_VOLTAGE];
  assign cmd_dis_op    = cmd_switch_on;
  assign cmd_en_op     = !cw[CW_FRESET] && cw[CW_ENOP] && cw[CW_QSTOP] && cw[CW_VOLTAGE]
                         && cw[CW_SWITCH];
  assign cmd_fault_rst = LINK.cyclic_up && LINK.controlword[CW_FRESET] && !fr_prev_ff;
  assign qs_auto       = (QS_OPTION >= QS_OPT_AUTO_MIN) && (QS_OPTION <= QS_OPT_AUTO_MAX);

  // edge detect only; master holds the bit long enough to be seen
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) fr_prev_ff <= 1'b0;
    else       fr_prev_ff <= LINK.cyclic_up && LINK.controlword[CW_FRESET];
  end

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  dsm_state_t state_ff;
  dsm_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_NOT_READY:    if (ctrl_ok) nxt_state = ST_SW_ON_DIS;
      ST_SW_ON_DIS: begin
        if (cmd_en_op && main_ok)          nxt_state = ST_OP_ENABLED;
        else if (cmd_switch_on && main_ok) nxt_state = ST_SWITCHED_ON;
        else if (cmd_shutdown)             nxt_state = ST_READY;
      end
      ST_READY: begin
        if (cmd_en_op && main_ok)                nxt_state = ST_OP_ENABLED;
        else if (cmd_switch_on && main_ok)       nxt_state = ST_SWITCHED_ON;
        else if (cmd_dis_volt || cmd_qstop)      nxt_state = ST_SW_ON_DIS;
      end
      ST_SWITCHED_ON: begin
        if (cmd_dis_volt || cmd_qstop) nxt_state = ST_SW_ON_DIS;
        else if (cmd_shutdown)         nxt_state = ST_READY;
        else if (cmd_en_op)            nxt_state = ST_OP_ENABLED;
      end
      ST_OP_ENABLED: begin
        if (cmd_dis_volt)                   nxt_state = ST_SW_ON_DIS;
        else if (cmd_qstop)                 nxt_state = ST_QSTOP_ACTIVE;
        else if (cmd_shutdown || !main_ok)  nxt_state = ST_READY;
        else if (cmd_dis_op)                nxt_state = ST_SWITCHED_ON;
      end
      ST_QSTOP_ACTIVE: begin
        // enable operation is ignored here: no way back to enabled
        if (cmd_dis_volt || (qs_auto && qstop_done)) nxt_state = ST_SW_ON_DIS;
      end
      ST_FAULT_REACT:  if (react_done) nxt_state = ST_FAULT;
      ST_FAULT:        if (cmd_fault_rst && ALARM_RESETTABLE) nxt_state = ST_SW_ON_DIS;
      default:         nxt_state = ST_NOT_READY;
    endcase
    // alarm pre-empts every state except not ready and those already handling it
    if (alarm && state_ff != ST_FAULT_REACT && state_ff != ST_FAULT && state_ff != ST_NOT_READY)
      nxt_state = ST_FAULT_REACT;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) state_ff <= ST_NOT_READY;
    else       state_ff <= nxt_state;
  end

  // ----------------------------------------
  // outputs, all registered; clear from current and next state, the rest from next state
  // ----------------------------------------
  logic relay_ff;
  logic servo_ff;
  logic decel_ff;
  logic clear_ff;
  logic fault_ff;

  // relay kept through quick stop and fault reaction so braking has power
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      relay_ff <= 1'b0;
    end else begin
      relay_ff <= (nxt_state == ST_SWITCHED_ON) || (nxt_state == ST_OP_ENABLED)
                  || (nxt_state == ST_QSTOP_ACTIVE) || (nxt_state == ST_FAULT_REACT);
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      servo_ff <= 1'b0;
    end else begin
      servo_ff <= (nxt_state == ST_OP_ENABLED) || (nxt_state == ST_QSTOP_ACTIVE)
                  || (nxt_state == ST_FAULT_REACT);
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      decel_ff <= 1'b0;
    end else begin
      decel_ff <= (nxt_state == ST_QSTOP_ACTIVE);
    end
  end

  // pulse only on the fault exit step, never while parked in fault
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      clear_ff <= 1'b0;
    end else begin
      clear_ff <= (state_ff == ST_FAULT) && (nxt_state == ST_SW_ON_DIS);
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      fault_ff <= 1'b0;
    end else begin
      fault_ff <= (nxt_state == ST_FAULT_REACT) || (nxt_state == ST_FAULT);
    end
  end

  assign LINK.state         = state_ff;
  assign MAIN_CIRCUIT_RELAY = relay_ff;
  assign SERVO_ON           = servo_ff;
  assign QSTOP_DECEL        = decel_ff;
  assign ALARM_CLEAR        = clear_ff;
  assign FAULT_ACTIVE       = fault_ff;

endmodule

// [rtl/dsm_master.sv]
// master end: takes a command over ahb-lite and drives the controlword
// assumes a single ahb-lite master on the same clock
`timescale 1ns/10ps
module dsm_master import dsm_pkg::*; #(
  parameter int FR_HOLD = FR_HOLD_CYCLES     // fault reset hold, cycles
) (
  input  wire logic        CLK,        // drive clock
  input  wire logic        RSTN,       // async reset, active low
  dsm_link_if.master       LINK,       // drive side
  input  wire logic        HSEL,       // ahb select
  input  wire logic [31:0] HADDR,      // ahb address
  input  wire logic [1:0]  HTRANS,     // ahb transfer type
  input  wire logic        HWRITE,     // ahb write
  input  wire logic [2:0]  HSIZE,      // ahb size
  input  wire logic [31:0] HWDATA,     // ahb write data
  input  wire logic        HREADY,     // ahb ready in
  output logic      [31:0] HRDATA,     // ahb read data
  output logic             HREADYOUT,  // ahb ready out
  output logic             HRESP       // ahb response, always okay
);

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00; // bit0 cyclic up
  localparam logic [7:0] OFS_CW     = 8'h04; // controlword
  localparam logic [7:0] OFS_STATUS = 8'h08; // drive state, fault reset busy
  localparam int         CNT_W      = $clog2(FR_HOLD + 1);

  logic              wr_pend_ff;
  logic [7:0]        wr_addr_ff;
  logic              rd_ff;
  logic [7:0]        rd_addr;
  logic              cyc_ff;
  logic [CW_W-1:0]   cw_ff;
  logic [CNT_W-1:0]  fr_cnt_ff;
  logic [31:0]       rdata_ff;
  logic              fr_busy;

  // ----------------------------------------
  // ahb slave, zero wait states
  // ----------------------------------------
  logic take;
  assign take    = HSEL && HREADY && HTRANS[1];
  assign rd_addr = HADDR[7:0];
  assign fr_busy = fr_cnt_ff != '0;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
    end else begin
      wr_pend_ff <= take && HWRITE;
      wr_addr_ff <= HADDR[7:0];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rd_ff    <= 1'b0;
      rdata_ff <= '0;
    end else begin
      rd_ff <= take && !HWRITE;
      if (take && !HWRITE) begin
        if (rd_addr == OFS_CTRL)        rdata_ff <= {31'h0, cyc_ff};
        else if (rd_addr == OFS_CW)     rdata_ff <= {16'h0, cw_ff};
        else if (rd_addr == OFS_STATUS) rdata_ff <= {27'h0, fr_busy, 1'b0, LINK.state};
        else                            rdata_ff <= '0;
      end
    end
  end

  // ----------------------------------------
  // controlword and fault reset hold
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cyc_ff <= 1'b0;
      cw_ff  <= CW_NONE;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == OFS_CTRL)    cyc_ff <= HWDATA[0];
      else if (wr_addr_ff == OFS_CW) cw_ff  <= HWDATA[CW_W-1:0];
    end else if (fr_cnt_ff == CNT_W'(1)) begin
      cw_ff[CW_FRESET] <= 1'b0;
    end
  end

  // a write setting fault reset from 0 starts the minimum hold; the bit
  // then drops on its own unless a write that leaves it set lands while the count is one, so the next reset makes a fresh rising edge
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) fr_cnt_ff <= '0;
    else if (wr_pend_ff && wr_addr_ff == OFS_CW && HWDATA[CW_FRESET] && !cw_ff[CW_FRESET])
      fr_cnt_ff <= CNT_W'(FR_HOLD);
    else if (wr_pend_ff && wr_addr_ff == OFS_CW && !HWDATA[CW_FRESET])
      fr_cnt_ff <= '0;
    else if (fr_busy)
      fr_cnt_ff <= fr_cnt_ff - CNT_W'(1);
  end

  assign LINK.cyclic_up   = cyc_ff;
  assign LINK.controlword = cw_ff;
  assign HRDATA    = rd_ff ? rdata_ff : 32'h0;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

endmodule

// [bench/dsm_asserts.sv]
// checker for the drive/master link: command decode and state stepping
// assumes it sits beside the link interface, fed by name from the bench
`timescale 1ns/10ps
module dsm_asserts import dsm_pkg::*; (
  input wire logic            CLK,                 // drive clock
  input wire logic            RSTN,                // async reset, active low
  input wire logic            cyclic_up,           // cyclic i/o up
  input wire logic [CW_W-1:0] controlword,         // master controlword
  input wire dsm_state_t      state,               // drive state
  input wire logic            MAIN_PWR_OK,         // main power raw
  input wire logic            MAIN_CIRCUIT_RELAY,  // relay closed
  input wire logic            SERVO_ON,            // servo on
  input wire logic            QSTOP_DECEL          // quick-stop decel
);
  logic [3:0]      pwr_hist_ff;
  logic [CW_W-1:0] cw_eff;
  logic            pwr_steady;
  logic            dv;
  logic            qs;
  logic            sh_dn;
  logic            sw_on;
  logic            en_op;
  // ----------------------------------------
  // decode as the drive sees it
  // ----------------------------------------
  assign cw_eff     = cyclic_up ? controlword : '0;
  assign pwr_steady = &pwr_hist_ff;
  assign dv    = !cw_eff[CW_FRESET] && !cw_eff[CW_VOLTAGE];
  assign qs    = !cw_eff[CW_FRESET] && !cw_eff[CW_QSTOP] && cw_eff[CW_VOLTAGE];
  assign sh_dn = {cw_eff[CW_FRESET], cw_eff[CW_QSTOP], cw_eff[CW_VOLTAGE], cw_eff[CW_SWITCH]} == 4'h6;
  assign sw_on = {cw_eff[CW_FRESET], cw_eff[3:0]} == 5'h07;
  assign en_op = {cw_eff[CW_FRESET], cw_eff[3:0]} == 5'h0f;
  // power seen steady longer than the drive's synchroniser needs
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pwr_hist_ff <= 4'h0;
    end else begin
      pwr_hist_ff <= {pwr_hist_ff[2:0], MAIN_PWR_OK};
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence s_off_line;
    (state == ST_SW_ON_DIS && !MAIN_CIRCUIT_RELAY && !SERVO_ON) || state == ST_FAULT_REACT;
  endsequence
  sequence s_relay_on;
    state inside {ST_SWITCHED_ON, ST_FAULT_REACT} && MAIN_CIRCUIT_RELAY;
  endsequence
  a_reset_not_ready: assert property ($rose(RSTN) |-> state == ST_NOT_READY)
    else $error("state not initial after reset");
  a_shutdown_ready: assert property (sh_dn && state inside {ST_SW_ON_DIS, ST_SWITCHED_ON, ST_OP_ENABLED}
    |=> state inside {ST_READY, ST_FAULT_REACT}) else $error("shutdown missed ready");
  a_switch_on_relay: assert property (sw_on && pwr_steady && state inside {ST_SW_ON_DIS, ST_READY}
    |=> s_relay_on) else $error("switch on missed");
  a_enable_servo: assert property (en_op && pwr_steady && state inside {ST_SW_ON_DIS, ST_READY, ST_SWITCHED_ON}
    |=> (state inside {ST_OP_ENABLED, ST_FAULT_REACT}) && SERVO_ON) else $error("enable op missed");
  a_disable_op: assert property (sw_on && pwr_steady && state == ST_OP_ENABLED
    |=> (state == ST_SWITCHED_ON && !SERVO_ON && MAIN_CIRCUIT_RELAY) || state == ST_FAULT_REACT)
    else $error("disable op missed");
  a_volt_off: assert property ((dv && state inside {ST_READY, ST_SWITCHED_ON, ST_OP_ENABLED, ST_QSTOP_ACTIVE})
    || (qs && state inside {ST_READY, ST_SWITCHED_ON}) |=> s_off_line) else $error("voltage off missed");
  a_quick_stop: assert property (qs && state == ST_OP_ENABLED
    |=> (state == ST_QSTOP_ACTIVE && QSTOP_DECEL) || state == ST_FAULT_REACT) else $error("quick stop missed");
  a_no_qs_return: assert property (state == ST_QSTOP_ACTIVE
    |=> state inside {ST_QSTOP_ACTIVE, ST_SW_ON_DIS, ST_FAULT_REACT}) else $error("left quick stop wrongly");
  a_output_map: assert property (MAIN_CIRCUIT_RELAY == (state inside {ST_SWITCHED_ON, ST_OP_ENABLED,
    ST_QSTOP_ACTIVE, ST_FAULT_REACT}) && SERVO_ON == (state inside {ST_OP_ENABLED, ST_QSTOP_ACTIVE, ST_FAULT_REACT}))
    else $error("relay or servo wrong for state");
endmodule

// [bench/dsm_tb.sv]
// bench for master and drive ends joined by the link interface
// assumes ahb-lite zero-wait slave and a shortened fault reset hold
`timescale 1ns/10ps
module testbench;
  import dsm_pkg::*;
  logic        CLK = 1'b0;
  logic        RSTN = 1'b0;
  logic        HSEL = 1'b0, HWRITE = 1'b0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA;
  logic [1:0]  HTRANS = 2'h0;
  logic [2:0]  HSIZE = 3'h2;
  logic        HREADY, HRESP;
  logic        CTRL_PWR_OK = 1'b1, MAIN_PWR_OK = 1'b1, ALARM = 1'b0, ALARM_RESETTABLE = 1'b0;
  logic        REACT_DONE = 1'b0, QSTOP_DONE = 1'b0;
  logic [3:0]  QS_OPTION = 4'h2;
  logic        MAIN_CIRCUIT_RELAY, SERVO_ON, QSTOP_DECEL, ALARM_CLEAR, FAULT_ACTIVE;
  int          errors = 0, checked = 0, cyc = 0, clr_cnt = 0;
  always #25 CLK = ~CLK;
  dsm_link_if lnk (.CLK(CLK));
  dsm_drive dsm_drive_i (.CLK(CLK), .RSTN(RSTN), .LINK(lnk), .CTRL_PWR_OK(CTRL_PWR_OK), .MAIN_PWR_OK(MAIN_PWR_OK),
    .ALARM(ALARM), .ALARM_RESETTABLE(ALARM_RESETTABLE), .REACT_DONE(REACT_DONE), .QSTOP_DONE(QSTOP_DONE),
    .QS_OPTION(QS_OPTION), .MAIN_CIRCUIT_RELAY(MAIN_CIRCUIT_RELAY), .SERVO_ON(SERVO_ON), .QSTOP_DECEL(QSTOP_DECEL),
    .ALARM_CLEAR(ALARM_CLEAR), .FAULT_ACTIVE(FAULT_ACTIVE));
  dsm_master #(.FR_HOLD(8)) dsm_master_i (.CLK(CLK), .RSTN(RSTN), .LINK(lnk), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADY), .HRESP(HRESP));
  dsm_asserts dsm_asserts_i (.CLK(CLK), .RSTN(RSTN), .cyclic_up(lnk.cyclic_up), .controlword(lnk.controlword),
    .state(lnk.state), .MAIN_PWR_OK(MAIN_PWR_OK), .MAIN_CIRCUIT_RELAY(MAIN_CIRCUIT_RELAY), .SERVO_ON(SERVO_ON),
    .QSTOP_DECEL(QSTOP_DECEL));
  // {controlword, expected state, relay, servo}; walks every command except fault reset
  logic [20:0] tbl [18] = '{
    {CW_SHUTDOWN, ST_READY, 2'b00}, {CW_SWITCH_ON, ST_SWITCHED_ON, 2'b10}, {CW_EN_OP, ST_OP_ENABLED, 2'b11},
    {CW_DIS_OP, ST_SWITCHED_ON, 2'b10}, {CW_SHUTDOWN, ST_READY, 2'b00}, {CW_DIS_VOLT, ST_SW_ON_DIS, 2'b00},
    {CW_SWITCH_ON, ST_SWITCHED_ON, 2'b10}, {CW_QUICKSTOP, ST_SW_ON_DIS, 2'b00}, {CW_EN_OP, ST_OP_ENABLED, 2'b11},
    {CW_SHUTDOWN, ST_READY, 2'b00}, {CW_EN_OP, ST_OP_ENABLED, 2'b11}, {CW_DIS_VOLT, ST_SW_ON_DIS, 2'b00},
    {CW_EN_OP, ST_OP_ENABLED, 2'b11}, {CW_QUICKSTOP, ST_QSTOP_ACTIVE, 2'b11}, {CW_EN_OP, ST_QSTOP_ACTIVE, 2'b11},
    {CW_DIS_VOLT, ST_SW_ON_DIS, 2'b00}, {CW_EN_OP, ST_OP_ENABLED, 2'b11}, {CW_QUICKSTOP, ST_QSTOP_ACTIVE, 2'b11}};
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= addr;
    HWRITE <= wr;
    @(posedge CLK);
    while (HREADY !== 1'b1) @(posedge CLK);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    @(posedge CLK);
    while (HREADY !== 1'b1) @(posedge CLK);
    rd = HRDATA;
  endtask
  task automatic step(input logic [15:0] cw, input logic [4:0] exp);
    logic [31:0] rd;
    ahb(1'b1, 32'h4, {16'h0, cw}, rd);
    repeat (4) @(posedge CLK);
    chk({27'h0, lnk.state, MAIN_CIRCUIT_RELAY, SERVO_ON}, {27'h0, exp});
    chk({31'h0, QSTOP_DECEL}, {31'h0, exp[4:2] == ST_QSTOP_ACTIVE});
  endtask
  task automatic summarize;
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (ALARM_CLEAR === 1'b1) clr_cnt++;
    if (cyc == 3000) begin
      errors++;
      summarize;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] rd;
    repeat (5) @(posedge CLK);
    chk({29'h0, lnk.state}, {29'h0, ST_NOT_READY});
    RSTN <= 1'b1;
    repeat (8) @(posedge CLK);
    chk({29'h0, lnk.state}, {29'h0, ST_SW_ON_DIS});
    step(CW_EN_OP, {ST_SW_ON_DIS, 2'b00});
    ahb(1'b1, 32'h0, 32'h1, rd);
    repeat (4) @(posedge CLK);
    chk({29'h0, lnk.state}, {29'h0, ST_OP_ENABLED});
    for (int i = 0; i < 18; i++) step(tbl[i][20:5], tbl[i][4:0]);
    QSTOP_DONE <= 1'b1;
    repeat (6) @(posedge CLK);
    chk({28'h0, lnk.state, MAIN_CIRCUIT_RELAY}, {28'h0, ST_SW_ON_DIS, 1'b0});
    QSTOP_DONE <= 1'b0;
    step(CW_EN_OP, {ST_OP_ENABLED, 2'b11});
    MAIN_PWR_OK <= 1'b0;
    repeat (6) @(posedge CLK);
    chk({28'h0, lnk.state, MAIN_CIRCUIT_RELAY}, {28'h0, ST_READY, 1'b0});
    step(CW_DIS_VOLT, {ST_SW_ON_DIS, 2'b00});
    MAIN_PWR_OK <= 1'b1;
    repeat (6) @(posedge CLK);
    step(CW_EN_OP, {ST_OP_ENABLED, 2'b11});
    ALARM <= 1'b1;
    repeat (6) @(posedge CLK);
    chk({28'h0, lnk.state, FAULT_ACTIVE}, {28'h0, ST_FAULT_REACT, 1'b1});
    REACT_DONE <= 1'b1;
    repeat (6) @(posedge CLK);
    chk({27'h0, lnk.state, MAIN_CIRCUIT_RELAY, SERVO_ON}, {27'h0, ST_FAULT, 2'b00});
    ALARM <= 1'b0;
    REACT_DONE <= 1'b0;
    ALARM_RESETTABLE <= 1'b1;
    ahb(1'b1, 32'h4, {16'h0, CW_FAULT_RST}, rd);
    ahb(1'b0, 32'h8, 32'h0, rd);
    chk({31'h0, rd[4]}, 32'h1);
    repeat (12) @(posedge CLK);
    chk({29'h0, lnk.state}, {29'h0, ST_SW_ON_DIS});
    chk(clr_cnt, 32'h1);
    ahb(1'b0, 32'h4, 32'h0, rd);
    chk({31'h0, rd[7]}, 32'h0);
    ahb(1'b0, 32'h8, 32'h0, rd);
    chk(rd, {29'h0, ST_SW_ON_DIS});
    ahb(1'b0, 32'h40, 32'h0, rd);
    chk(rd, 32'h0);
    chk({31'h0, HRESP}, 32'h0);
    summarize;
  end
endmodule
